// [stw_pkg.sv]
// Constants, register map and types shared by the two-wire slave files.
package stw_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] ADDR_MODE     = 8'h9c;
  localparam logic [7:0] ADDR_CTRL     = 8'h9d;
  localparam logic [7:0] ADDR_OWN      = 8'h9e;
  localparam logic [7:0] ADDR_DATA     = 8'h9f;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'ha0;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'ha1;

  // Serial unit selector value that picks the two-wire interface.
  localparam logic [1:0] SEL_TWOWIRE   = 2'b10;

  // Field positions of the control register.
  localparam int CTRL_EN_BIT  = 7;
  localparam int CTRL_EVT_BIT = 6;
  localparam int CTRL_GCH_BIT = 4;
  localparam int CTRL_ACK_BIT = 3;

  // Field positions of the own-address register.
  localparam int OWN_GC_BIT   = 0;
  localparam int OWN_ADDR_LSB = 1;
  localparam int OWN_ADDR_MSB = 7;

  // Byte framing on the wire.
  localparam int         BYTE_MSB      = 7;
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [3:0] BIT_ACK       = 4'h8;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;

  // Reset values.
  localparam logic [1:0] SEL_RST  = 2'b00;
  localparam logic [6:0] OWN_RST  = 7'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] BIT_RST  = 4'h0;
  localparam logic [3:0] EV_RST   = 4'h0;

  // Event positions in the interrupt status and mask registers.
  localparam int EV_MATCH  = 0;
  localparam int EV_BYTE   = 1;
  localparam int EV_RSTART = 2;
  localparam int EV_STOP   = 3;
  localparam int EV_N      = 4;

  // Protocol state as software reads it.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_RX    = 3'b010,
    ST_TX    = 3'b011,
    ST_NACKD = 3'b100,
    ST_ABORT = 3'b101
  } stw_state_t;

  // The two bus lines travel together.
  typedef struct packed {
    logic scl;
    logic sda;
  } stw_pins_t;

endpackage

// [stw_sync.sv]
// Two-flop synchroniser for the bus lines with a delayed copy for edge finding.
`timescale 1ns/10ps
module stw_sync (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Raw pins and synchronised levels.
  input  wire stw_pkg::stw_pins_t pins_i,
  output stw_pkg::stw_pins_t      now_o,
  output stw_pkg::stw_pins_t      prev_o
);

  stw_pkg::stw_pins_t meta_reg;
  stw_pkg::stw_pins_t now_reg;
  stw_pkg::stw_pins_t prev_reg;

  // Lines idle high, so reset to the released level to avoid a false start.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '{scl: 1'b1, sda: 1'b1};
      now_reg  <= '{scl: 1'b1, sda: 1'b1};
      prev_reg <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      meta_reg <= pins_i;
      now_reg  <= meta_reg;
      prev_reg <= now_reg;
    end
  end

  assign now_o  = now_reg;
  assign prev_o = prev_reg;

endmodule

// [stw_slave.sv]
// Two-wire slave of the shared serial unit with its register file.
//
// How it works
// (RULE_01) Selector value 10 picks the two-wire mode; it only ever acts as slave.
// (RULE_02) State 000 is idle, waiting for enable and start; stop returns here.
// (RULE_03) A start enters state 001 to take seven address bits and a read bit.
// (RULE_04) State 010 while receiving bytes, 011 while sending bytes.
// (RULE_05) A master not-acknowledge while sending moves to 100 and releases the bus.
// (RULE_06) Clearing ack enable while sending moves to 101 after the current byte.
// (RULE_07) Event flag bit 6 set on match, byte, repeated start, stop; software clears.
// (RULE_08) General call hit flag bit 4 set by hardware, cleared by hardware.
// (RULE_09) Ack enable bit 3 chooses between accepting and refusing the master.
// (RULE_10) Own address sits in bits 7 to 1; zero is reserved for general call.
// (RULE_11) Bit 0 enables general call answers; otherwise such frames are ignored.
// (RULE_12) Data buffer holds the last byte received or the byte to send.
// (RULE_13) A matched slave pulls data low in the ninth clock, then releases.
// (RULE_14) Receiving with ack enable cleared answers high and returns to idle.
// (RULE_15) The master sends write direction with a general call address.
// (RULE_16) After a master acknowledge the slave sends the next buffered byte.
// (RULE_17) Both lines are sampled on the system clock to find start and stop.
// (RULE_18) Data is only pulled low or released; the clock line is never driven.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module stw_slave (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Register port.
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Bus lines.
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Interrupt.
  output logic            irq_o
);

  // Raw and synchronised lines.
  stw_pkg::stw_pins_t pins_raw;
  stw_pkg::stw_pins_t pins_now;
  stw_pkg::stw_pins_t pins_prev;

  // Registers and their next values.
  logic [1:0]            sel_reg;
  logic                  en_reg;
  logic                  evt_reg;
  logic                  evt_next;
  logic                  gch_reg;
  logic                  gch_next;
  logic                  ack_en_reg;
  logic [6:0]            own_reg;
  logic                  gc_en_reg;
  logic [7:0]            buf_reg;
  logic [7:0]            buf_next;
  stw_pkg::stw_state_t   state_reg;
  stw_pkg::stw_state_t   state_next;
  logic [3:0]            bit_reg;
  logic [3:0]            bit_next;
  logic [7:0]            shift_reg;
  logic [7:0]            shift_next;
  logic                  rw_reg;
  logic                  rw_next;
  logic                  lead_reg;
  logic                  lead_next;
  logic                  nack_reg;
  logic                  nack_next;
  logic                  drive_reg;
  logic                  drive_next;
  logic                  load_buf;
  logic [3:0]            ist_reg;
  logic [3:0]            ist_next;
  logic [3:0]            imsk_reg;
  logic [7:0]            rdata_reg;
  logic                  irq_reg;
  logic                  sda_lvl_reg;

  // Decoded strobes and conditions.
  wire        wr_mode  = wr_i && (addr_i == stw_pkg::ADDR_MODE);
  wire        wr_ctrl  = wr_i && (addr_i == stw_pkg::ADDR_CTRL);
  wire        wr_own   = wr_i && (addr_i == stw_pkg::ADDR_OWN);
  wire        wr_data  = wr_i && (addr_i == stw_pkg::ADDR_DATA);
  wire        wr_istat = wr_i && (addr_i == stw_pkg::ADDR_IRQ_STAT);
  wire        wr_imask = wr_i && (addr_i == stw_pkg::ADDR_IRQ_MASK);
  wire        active   = en_reg && (sel_reg == stw_pkg::SEL_TWOWIRE); // [RULE_01]
  wire        scl_rise = pins_now.scl && !pins_prev.scl;
  wire        scl_fall = !pins_now.scl && pins_prev.scl;
  wire        scl_high = pins_now.scl && pins_prev.scl;
  wire        start    = scl_high && !pins_now.sda && pins_prev.sda; // [RULE_17]
  wire        stop     = scl_high && pins_now.sda && !pins_prev.sda; // [RULE_17]
  wire [6:0]  frame    = shift_reg[stw_pkg::BYTE_MSB:1];
  wire        own_ok   = (own_reg != stw_pkg::GEN_CALL_ADDR); // [RULE_10]
  wire        own_hit  = own_ok && (frame == own_reg); // [RULE_10]
  wire        gc_hit   = gc_en_reg && (frame == stw_pkg::GEN_CALL_ADDR)
                         && !shift_reg[0]; // [RULE_11] [RULE_15]
  wire        match    = own_hit || gc_hit;
  wire        busy     = (state_reg != stw_pkg::ST_IDLE);
  wire        at_last  = scl_fall && (bit_reg == stw_pkg::BIT_LAST);
  wire        in_data  = (state_reg == stw_pkg::ST_RX) || (state_reg == stw_pkg::ST_TX);
  wire [3:0]  ev;
  wire [7:0]  ctrl_rd;
  wire [7:0]  rd_mux;

  // Events only count while the interface is active; a start or stop blocks the match and byte events.
  assign ev[stw_pkg::EV_MATCH]  = active && !start && !stop && at_last
                                  && (state_reg == stw_pkg::ST_ADDR)
                                  && match && ack_en_reg; // [RULE_07]
  assign ev[stw_pkg::EV_BYTE]   = active && !start && !stop && at_last && in_data; // [RULE_07]
  assign ev[stw_pkg::EV_RSTART] = active && start && busy; // [RULE_07]
  assign ev[stw_pkg::EV_STOP]   = active && stop && busy; // [RULE_07]

  assign ctrl_rd = {en_reg, evt_reg, 1'b0, gch_reg, ack_en_reg, state_reg};

  assign rd_mux = (addr_i == stw_pkg::ADDR_MODE)     ? {6'h00, sel_reg} :
                  (addr_i == stw_pkg::ADDR_CTRL)     ? ctrl_rd :
                  (addr_i == stw_pkg::ADDR_OWN)      ? {own_reg, gc_en_reg} :
                  (addr_i == stw_pkg::ADDR_DATA)     ? buf_reg :
                  (addr_i == stw_pkg::ADDR_IRQ_STAT) ? {4'h0, ist_reg} :
                  (addr_i == stw_pkg::ADDR_IRQ_MASK) ? {4'h0, imsk_reg} :
                  8'h00;

  assign pins_raw = '{scl: scl_i, sda: sda_i};

  stw_sync u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pins_i (pins_raw),
    .now_o  (pins_now),
    .prev_o (pins_prev)
  );

  // Protocol engine. The slave changes data only after a clock fall, so its own
  // drive never looks like a start or stop to itself.
  always_comb begin
    state_next = state_reg;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    rw_next    = rw_reg;
    lead_next  = lead_reg;
    nack_next  = nack_reg;
    drive_next = drive_reg;
    gch_next   = gch_reg;
    load_buf   = 1'b0;
    if (!active) begin
      state_next = stw_pkg::ST_IDLE; // [RULE_02]
      lead_next  = 1'b0;
      drive_next = 1'b0;
      gch_next   = 1'b0;
    end else if (stop) begin
      state_next = stw_pkg::ST_IDLE; // [RULE_02]
      drive_next = 1'b0;
      gch_next   = 1'b0; // [RULE_08]
    end else if (start) begin
      state_next = stw_pkg::ST_ADDR; // [RULE_03]
      bit_next   = stw_pkg::BIT_RST;
      lead_next  = 1'b1;
      drive_next = 1'b0;
      nack_next  = 1'b0;
      gch_next   = 1'b0; // [RULE_08]
    end else if (scl_fall && lead_reg) begin
      // The clock fall that closes a start is no data clock; counting it would
      // slip the address frame by one bit.
      lead_next  = 1'b0; // [RULE_03]
    end else if (scl_rise) begin
      case (state_reg)
        stw_pkg::ST_ADDR,
        stw_pkg::ST_RX: begin
          if (bit_reg != stw_pkg::BIT_ACK) begin
            shift_next = {shift_reg[stw_pkg::BYTE_MSB-1:0], pins_now.sda}; // [RULE_03]
          end
        end
        stw_pkg::ST_TX: begin
          if (bit_reg == stw_pkg::BIT_ACK) begin
            nack_next = pins_now.sda;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      bit_next = (bit_reg == stw_pkg::BIT_ACK) ? stw_pkg::BIT_RST : bit_reg + 4'h1;
      case (state_reg)
        stw_pkg::ST_ADDR: begin
          if (bit_reg == stw_pkg::BIT_LAST) begin
            if (match && ack_en_reg) begin
              drive_next = 1'b1; // [RULE_13] [RULE_09]
              rw_next    = shift_reg[0]; // [RULE_03]
              gch_next   = gc_hit; // [RULE_08]
            end else begin
              state_next = stw_pkg::ST_IDLE; // [RULE_11]
            end
          end else if (bit_reg == stw_pkg::BIT_ACK) begin
            if (rw_reg) begin
              state_next = stw_pkg::ST_TX; // [RULE_04]
              shift_next = buf_reg; // [RULE_12]
              drive_next = !buf_reg[stw_pkg::BYTE_MSB];
            end else begin
              state_next = stw_pkg::ST_RX; // [RULE_04]
              drive_next = 1'b0; // [RULE_13]
            end
          end
        end
        stw_pkg::ST_RX: begin
          if (bit_reg == stw_pkg::BIT_LAST) begin
            load_buf   = 1'b1; // [RULE_12]
            drive_next = ack_en_reg; // [RULE_09] [RULE_14]
            nack_next  = !ack_en_reg;
          end else if (bit_reg == stw_pkg::BIT_ACK) begin
            drive_next = 1'b0;
            if (nack_reg) begin
              state_next = stw_pkg::ST_IDLE; // [RULE_14]
            end
          end
        end
        stw_pkg::ST_TX: begin
          if (bit_reg < stw_pkg::BIT_LAST) begin
            shift_next = {shift_reg[stw_pkg::BYTE_MSB-1:0], 1'b0};
            drive_next = !shift_reg[stw_pkg::BYTE_MSB-1];
          end else if (bit_reg == stw_pkg::BIT_LAST) begin
            drive_next = 1'b0;
          end else if (nack_reg) begin
            state_next = stw_pkg::ST_NACKD; // [RULE_05]
            drive_next = 1'b0; // [RULE_05]
          end else if (!ack_en_reg) begin
            state_next = stw_pkg::ST_ABORT; // [RULE_06]
            drive_next = 1'b0; // [RULE_06]
          end else begin
            shift_next = buf_reg; // [RULE_16]
            drive_next = !buf_reg[stw_pkg::BYTE_MSB]; // [RULE_16]
          end
        end
        default: begin
          drive_next = 1'b0;
        end
      endcase
    end
  end

  // A received byte wins over a software write in the same cycle, so no byte is lost.
  assign buf_next = load_buf ? shift_reg : (wr_data ? wdata_i : buf_reg); // [RULE_12]

  // Hardware set wins over a software clear in the same cycle.
  assign evt_next = (|ev) || (evt_reg && !(wr_ctrl && !wdata_i[stw_pkg::CTRL_EVT_BIT])); // [RULE_07]
  assign ist_next = ev | (ist_reg & ~(wr_istat ? wdata_i[3:0] : 4'h0));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= stw_pkg::ST_IDLE;
      bit_reg   <= stw_pkg::BIT_RST;
      shift_reg <= stw_pkg::BYTE_RST;
      rw_reg    <= 1'b0;
      lead_reg  <= 1'b0;
      nack_reg  <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      rw_reg    <= rw_next;
      lead_reg  <= lead_next;
      nack_reg  <= nack_next;
      drive_reg <= drive_next; // [RULE_18]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_reg    <= stw_pkg::SEL_RST;
      en_reg     <= 1'b0;
      ack_en_reg <= 1'b0;
      own_reg    <= stw_pkg::OWN_RST;
      gc_en_reg  <= 1'b0;
    end else begin
      if (wr_mode) begin
        sel_reg <= wdata_i[1:0]; // [RULE_01]
      end
      if (wr_ctrl) begin
        en_reg     <= wdata_i[stw_pkg::CTRL_EN_BIT];
        ack_en_reg <= wdata_i[stw_pkg::CTRL_ACK_BIT]; // [RULE_09]
      end
      if (wr_own) begin
        own_reg   <= wdata_i[stw_pkg::OWN_ADDR_MSB:stw_pkg::OWN_ADDR_LSB]; // [RULE_10]
        gc_en_reg <= wdata_i[stw_pkg::OWN_GC_BIT]; // [RULE_11]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_reg  <= 1'b0;
      gch_reg  <= 1'b0;
      buf_reg  <= stw_pkg::BYTE_RST;
      ist_reg  <= stw_pkg::EV_RST;
      imsk_reg <= stw_pkg::EV_RST;
    end else begin
      evt_reg <= evt_next;
      gch_reg <= gch_next;
      buf_reg <= buf_next;
      ist_reg <= ist_next;
      if (wr_imask) begin
        imsk_reg <= wdata_i[stw_pkg::EV_N-1:0];
      end
    end
  end

  // Outputs come straight from flops; the data line is open drain and only pulled low.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg   <= stw_pkg::BYTE_RST;
      irq_reg     <= 1'b0;
      sda_lvl_reg <= 1'b0;
    end else begin
      rdata_reg   <= rd_i ? rd_mux : stw_pkg::BYTE_RST;
      irq_reg     <= |(ist_reg & imsk_reg);
      sda_lvl_reg <= 1'b0; // [RULE_18]
    end
  end

  assign rdata_o  = rdata_reg;
  assign irq_o    = irq_reg;
  assign sda_o    = sda_lvl_reg;
  assign sda_oe_o = drive_reg;

endmodule

// [stw_slave_assertions.sv]
// Port-level checks for the two-wire slave, bound to its top module.
`timescale 1ns/10ps
module stw_slave_assertions (
  // Clock and reset.
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  // Bus lines and interrupt.
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       irq_o
);
  // Mirrors of software writes, so the checker knows when the unit is switched off.
  logic [1:0] sel_q;
  logic       en_q;
  wire        off_w = (sel_q != stw_pkg::SEL_TWOWIRE) || !en_q;
  wire        rd_ctl_w = rd_i && (addr_i == stw_pkg::ADDR_CTRL);
  wire        rd_own_w = rd_i && (addr_i == stw_pkg::ADDR_OWN);
  wire        wr_own_w = wr_i && (addr_i == stw_pkg::ADDR_OWN);
  wire        mask_off_w = wr_i && (addr_i == stw_pkg::ADDR_IRQ_MASK) && (wdata_i == 8'h00);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q <= 2'h0;
      en_q  <= 1'b0;
    end else begin
      if (wr_i && addr_i == stw_pkg::ADDR_MODE) sel_q <= wdata_i[1:0];
      if (wr_i && addr_i == stw_pkg::ADDR_CTRL) en_q <= wdata_i[stw_pkg::CTRL_EN_BIT];
    end
  end
  a_sda_never_high: assert property (sda_o == 1'b0)
    else $error("sda_o driven high");
  a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("rdata_o not zero outside a read");
  a_oe_moves_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 2))
    else $error("sda_oe_o moved while the clock line was high");
  a_oe_holds_high: assert property ($rose(scl_i) |=> $stable(sda_oe_o) [*2])
    else $error("sda_oe_o moved after a clock rise");
  a_own_reads_back: assert property (wr_own_w ##2 rd_own_w |=> rdata_o == $past(wdata_i, 3))
    else $error("own address did not read back");
  a_state_code_legal: assert property (rd_ctl_w |=> rdata_o[2:0] <= 3'b101 && !rdata_o[5])
    else $error("illegal control read value");
  a_mask_off_quiet: assert property (mask_off_w |-> ##2 !irq_o)
    else $error("irq_o high with all events masked");
  a_off_no_drive: assert property (off_w |-> ##2 !sda_oe_o)
    else $error("data line driven while switched off");
  c_ctl_read: cover property (rd_ctl_w);
  c_ack_drive: cover property ($rose(sda_oe_o));
  c_irq_rise: cover property ($rose(irq_o));
endmodule
bind stw_slave stw_slave_assertions stw_slave_assertions_i (
  .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .scl_i, .sda_i, .sda_o, .sda_oe_o, .irq_o
);

// [stw_master_model.sv]
// Behavioural bus master that clocks bytes to and from the slave.
`timescale 1ns/10ps
module stw_master_model (
  // Clock.
  input  wire logic clk_i,
  // Bus lines; the bench resolves the wired data line.
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      pull_o
);
  // Idle bus: clock high, data released to the pull-up.
  initial begin
    scl_o  = 1'b1;
    pull_o = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Data is set four cycles before the rise and held four after it.
  task automatic bit_io(input logic b, output logic r);
    pull_o <= !b;
    hold(4);
    scl_o <= 1'b1;
    hold(2);
    r = sda_i;
    hold(1);
    scl_o <= 1'b0;
    hold(1);
  endtask
  // Data moves while the clock is high: falling is a start, rising a stop.
  task automatic edge_cond(input logic a, input logic b);
    pull_o <= !a;
    hold(4);
    scl_o <= 1'b1;
    hold(4);
    pull_o <= !b;
    hold(4);
  endtask
  // Also serves as a repeated start.
  task automatic send_start;
    edge_cond(1'b1, 1'b0);
    scl_o <= 1'b0;
    hold(1);
  endtask
  task automatic send_stop;
    edge_cond(1'b0, 1'b1);
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, r);
  endtask
endmodule

// [stw_slave_tb_top.sv]
// Self-checking bench for the two-wire slave and its register port.
`timescale 1ns/10ps
module stw_slave_tb_top;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic       scl_w;
  logic       pull_w;
  logic       sda_o;
  logic       sda_oe_o;
  logic       irq_o;
  logic [7:0] q;
  logic       r;
  int         n_errors = 0;
  int         compares = 0;
  // The data line is wired-AND with a pull-up.
  wire        sda_w = !(sda_oe_o || pull_w);
  always #20 clk_i = !clk_i;
  stw_slave stw_slave_i (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .scl_i(scl_w), .sda_i(sda_w), .sda_o, .sda_oe_o, .irq_o);
  stw_master_model stw_master_model_i (.clk_i, .sda_i(sda_w), .scl_o(scl_w), .pull_o(pull_w));
  task automatic give_verdict;
    $display("compares %0d, n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(posedge clk_i);
    chk(rdata_o, exp);
  endtask
  task automatic ctl(input logic [7:0] exp);
    rd(stw_pkg::ADDR_CTRL, exp);
  endtask
  task automatic clr;
    wr(stw_pkg::ADDR_IRQ_STAT, 8'h0f);
    wr(stw_pkg::ADDR_CTRL, 8'h88);
  endtask
  task automatic gap;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic adr(input logic [7:0] a, input logic ack);
    stw_master_model_i.send_start();
    stw_master_model_i.xfer(a, 1'b1, q, r);
    chk({7'h00, r}, {7'h00, ack});
    gap();
  endtask
  task automatic byte_rw(input logic [7:0] d, input logic a, input logic [7:0] eq, input logic er);
    stw_master_model_i.xfer(d, a, q, r);
    chk(q, eq);
    chk({7'h00, r}, {7'h00, er});
    gap();
  endtask
  task automatic t_reset;
    for (int a = 8'h9c; a <= 8'ha1; a++) rd(8'(a), 8'h00);
    rd(8'h10, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_write;
    adr(8'h54, 1'b0);
    ctl(8'hca);
    chk({7'h00, irq_o}, 8'h01);
    clr();
    ctl(8'h8a);
    byte_rw(8'ha5, 1'b1, 8'ha5, 1'b0);
    rd(stw_pkg::ADDR_DATA, 8'ha5);
    rd(stw_pkg::ADDR_IRQ_STAT, 8'h02);
    clr();
    stw_master_model_i.send_stop();
    ctl(8'hc8);
    rd(stw_pkg::ADDR_IRQ_STAT, 8'h08);
    wr(stw_pkg::ADDR_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h00);
    wr(stw_pkg::ADDR_IRQ_MASK, 8'h0f);
    clr();
    repeat (2) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h00);
    adr(8'h56, 1'b1);
    ctl(8'h88);
    stw_master_model_i.send_stop();
    $display("t_write done");
  endtask
  task automatic t_read;
    wr(stw_pkg::ADDR_DATA, 8'h3c);
    adr(8'h55, 1'b0);
    ctl(8'hcb);
    wr(stw_pkg::ADDR_DATA, 8'hc3);
    clr();
    byte_rw(8'hff, 1'b0, 8'h3c, 1'b0);
    byte_rw(8'hff, 1'b1, 8'hc3, 1'b1);
    ctl(8'hcc);
    chk({7'h00, sda_oe_o}, 8'h00);
    clr();
    stw_master_model_i.send_start();
    gap();
    ctl(8'hc9);
    rd(stw_pkg::ADDR_IRQ_STAT, 8'h04);
    stw_master_model_i.send_stop();
    clr();
    wr(stw_pkg::ADDR_DATA, 8'h5a);
    adr(8'h55, 1'b0);
    fork
      byte_rw(8'hff, 1'b0, 8'h5a, 1'b0);
      begin
        repeat (20) @(posedge clk_i);
        wr(stw_pkg::ADDR_CTRL, 8'hc0);
      end
    join
    ctl(8'hc5);
    stw_master_model_i.send_stop();
    ctl(8'hc0);
    $display("t_read done");
  endtask
  task automatic t_refuse;
    clr();
    adr(8'h54, 1'b0);
    wr(stw_pkg::ADDR_CTRL, 8'h80);
    byte_rw(8'h77, 1'b1, 8'h77, 1'b1);
    ctl(8'hc0);
    stw_master_model_i.send_stop();
    clr();
    adr(8'h00, 1'b0);
    ctl(8'hda);
    stw_master_model_i.send_stop();
    ctl(8'hc8);
    wr(stw_pkg::ADDR_OWN, 8'h54);
    adr(8'h00, 1'b1);
    stw_master_model_i.send_stop();
    wr(stw_pkg::ADDR_OWN, 8'h55);
    wr(stw_pkg::ADDR_MODE, 8'h00);
    adr(8'h55, 1'b1);
    stw_master_model_i.send_stop();
    $display("t_refuse done");
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    wr(stw_pkg::ADDR_MODE, {6'h00, stw_pkg::SEL_TWOWIRE});
    wr(stw_pkg::ADDR_OWN, 8'h55);
    rd(stw_pkg::ADDR_OWN, 8'h55);
    wr(stw_pkg::ADDR_IRQ_MASK, 8'h0f);
    wr(stw_pkg::ADDR_CTRL, 8'h88);
    rd(stw_pkg::ADDR_MODE, 8'h02);
    t_write();
    t_read();
    t_refuse();
    give_verdict();
  end
endmodule
